// ==== fftc_table_ctrl.sv ====
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - Pending command clears within two reads.
// - Control rewrite with init flag clear reinitialises.
// - Init flag set when initialisation finishes.
// - Match/miss clear on read, others writable.
// - Nonzero allocation write enables and reinitialises.
// - Init time follows link speed.
// - Query result returned; code cleared on completion.
// - Signature mode omits pool from query result.
// - Hash and command registers adjacent, 8-byte aligned.
// - Command register write starts programming.
// - Two keyed 16-bit hashes: bucket, signature.
// - Narrower hashes use least significant bits.
// - Hash XORs windows where key bit set.
// - Input is 42 masked tuple bytes.
// - Extended input wraps fifteen bits each end.
// - Key repeated eleven times, bit 0 dropped.
// - Byte 0 is VLAN high byte.
// - Tunnelled packets hash inner IP addresses.
// - Bucket lookup uses a 15-bit hash.
module fftc_table_ctrl #(
   parameter int unsigned INIT_CYC_10G = fftc_pkg::INIT_CYC_10G,
   parameter int unsigned INIT_CYC_1G = fftc_pkg::INIT_CYC_1G,
   parameter int unsigned INIT_CYC_100M = fftc_pkg::INIT_CYC_100M
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cmdStart,
   output logic [1:0] cmdCode,
   output logic cmdUpdate,
   output logic [31:0] cmdHashSig,
   input wire logic cmdDone,
   input wire logic [31:0] cmdDoneHash,
   input wire logic [7:0] cmdDoneAction,
   input wire logic [5:0] cmdDonePool,
   input wire logic [7:0] cmdDoneLen,
   output logic tableClear,
   output logic tableEnable,
   output logic initBusy,
   output logic sigMode,
   output logic [2:0] bufferAllocation,
   input wire logic matchEvt,
   input wire logic missEvt,
   input wire logic addOkEvt,
   input wire logic removeOkEvt,
   input wire logic addFailEvt,
   input wire logic removeFailEvt,
   input wire logic pktValid,
   input wire logic pktTunnel,
   input wire logic [15:0] pktVlan,
   input wire logic [127:0] pktOuterSrcIp,
   input wire logic [127:0] pktOuterDstIp,
   input wire logic [127:0] pktInnerSrcIp,
   input wire logic [127:0] pktInnerDstIp,
   input wire logic [15:0] pktSrcPort,
   input wire logic [15:0] pktDstPort,
   input wire logic [31:0] pktFlex,
   input wire logic [335:0] tupleMask,
   output logic [14:0] bucketHash,
   output logic [15:0] signatureHash,
   output logic hashValid
);
   import fftc_pkg::*;

   // ****************************************************************
   // Bus decode.
   // ****************************************************************
   logic [31:0] ctrl_q, free_q, hash_q, cmd_q, ustat_q, fstat_q;
   logic [31:0] match_q, miss_q, len_q, hkey_q, skey_q;
   logic [31:0] rdata_q;
   logic [19:0] initCnt_q;
   logic initBusy_q, hashValid_q, cmdStart_q;
   logic [2:0] cmdAge_q;

   wire access = psel && penable;
   wire wrAcc = access && pwrite;
   wire rdAcc = access && !pwrite;
   wire wrCtrl = wrAcc && paddr == OFS_CTRL;
   wire wrFree = wrAcc && paddr == OFS_FREE;
   wire wrHash = wrAcc && paddr == OFS_HASH;
   wire wrCmd = wrAcc && paddr == OFS_CMD;
   wire wrUstat = wrAcc && paddr == OFS_USTAT;
   wire wrFstat = wrAcc && paddr == OFS_FSTAT;
   wire wrLen = wrAcc && paddr == OFS_LEN;
   wire wrHkey = wrAcc && paddr == OFS_HKEY;
   wire wrSkey = wrAcc && paddr == OFS_SKEY;
   wire rdMatch = rdAcc && paddr == OFS_MATCH;
   wire rdMiss = rdAcc && paddr == OFS_MISS;
   wire mapped = paddr[7:2] <= OFS_RESULT[7:2] && paddr[1:0] == 2'b00;

   // Zero-wait slave; unmapped or misaligned addresses answer with an error.
   assign pready = access;
   assign pslverr = access && !mapped;
   assign prdata = rdata_q;

   // ****************************************************************
   // Control register and table initialisation.
   // ****************************************************************
   wire [2:0] allocWr = pwdata[CTRL_ALLOC_LSB +: 3];
   wire [1:0] speedSel = pwdata[CTRL_SPEED_LSB +: 2]; // Speed comes with the starting write.
   wire initReq = wrCtrl && (allocWr != 3'h0 ||
      (!pwdata[CTRL_INIT_DONE] && ctrl_q[CTRL_ALLOC_LSB +: 3] != 3'h0));
   wire [19:0] initLen;
   wire initLast = initBusy_q && initCnt_q == 20'h00001;

   // Initialisation length follows the link speed.
   assign initLen = (speedSel == FFTC_SPD_10G) ? 20'(INIT_CYC_10G) :
      (speedSel == FFTC_SPD_1G) ? 20'(INIT_CYC_1G) : 20'(INIT_CYC_100M);

   // The whole register is taken from one write; hardware owns the init flag.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_q <= CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_q <= {pwdata[31:CTRL_INIT_DONE + 1], 1'b0, pwdata[CTRL_INIT_DONE - 1:0]};
      end else if (initLast) begin
         ctrl_q[CTRL_INIT_DONE] <= 1'b1;
      end
   end

   // Initialisation counter runs down the table walk time.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         initBusy_q <= 1'b0;
         initCnt_q <= 20'h00000;
      end else if (initReq) begin
         initBusy_q <= 1'b1;
         initCnt_q <= initLen;
      end else if (initBusy_q) begin
         initBusy_q <= !initLast;
         initCnt_q <= initCnt_q - 20'h00001;
      end
   end

   assign initBusy = initBusy_q;
   assign tableEnable = ctrl_q[CTRL_ALLOC_LSB +: 3] != 3'h0;
   assign bufferAllocation = ctrl_q[CTRL_ALLOC_LSB +: 3];
   assign sigMode = ctrl_q[CTRL_SIG_MODE];

   // ****************************************************************
   // Command register and table command handshake.
   // ****************************************************************
   wire cmdPending = cmd_q[CMD_CODE_LSB +: 2] != FFTC_CMD_IDLE;
   wire [1:0] codeWr = pwdata[CMD_CODE_LSB +: 2];
   wire cmdGo = wrCmd && codeWr != FFTC_CMD_IDLE && !cmdPending;
   wire cmdTimeout = cmdPending && cmdAge_q >= CMD_MAX_CYC;
   wire cmdEnd = cmdPending && (cmdDone || cmdTimeout);
   wire queryEnd = cmdPending && cmdDone &&
      cmd_q[CMD_CODE_LSB +: 2] == FFTC_CMD_QUERY;
   wire [5:0] poolRet = sigMode ? 6'h00 : cmdDonePool;

   // Code field stays set while pending and is cleared on completion.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmd_q <= 32'h0000_0000;
      end else if (queryEnd) begin
         cmd_q[CMD_CODE_LSB +: 2] <= FFTC_CMD_IDLE;
         cmd_q[CMD_ACTION_LSB +: 8] <= cmdDoneAction;
         cmd_q[CMD_POOL_LSB +: 6] <= poolRet;
      end else if (cmdEnd) begin
         cmd_q[CMD_CODE_LSB +: 2] <= FFTC_CMD_IDLE;
      end else if (wrCmd) begin
         cmd_q <= cmdPending ? {pwdata[31:2], cmd_q[1:0]} : pwdata;
      end
   end

   // Age counter bounds a pending command so it never outlives two reads.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmdAge_q <= 3'h0;
      end else if (!cmdPending) begin
         cmdAge_q <= 3'h0;
      end else begin
         cmdAge_q <= cmdAge_q + 3'h1;
      end
   end

   // Start pulse and its operands go to the table engine.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmdStart_q <= 1'b0;
      end else begin
         cmdStart_q <= cmdGo;
      end
   end

   assign cmdStart = cmdStart_q;
   assign cmdCode = cmd_q[CMD_CODE_LSB +: 2];
   assign cmdUpdate = cmd_q[CMD_UPDATE];
   assign cmdHashSig = hash_q;
   assign tableClear = cmd_q[CMD_CLEAR_HT];

   // ****************************************************************
   // Hash, free count, keys and list length.
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hash_q <= 32'h0000_0000;
         hkey_q <= KEY_RESET;
         skey_q <= KEY_RESET;
      end else begin
         if (queryEnd) begin
            hash_q <= cmdDoneHash;
         end else if (wrHash) begin
            hash_q <= pwdata;
         end
         if (wrHkey) begin
            hkey_q <= pwdata;
         end
         if (wrSkey) begin
            skey_q <= pwdata;
         end
      end
   end

   // Free count follows adds and removes; software may overwrite it.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         free_q <= 32'h0000_0000;
         len_q <= 32'h0000_0000;
      end else begin
         if (wrFree) begin
            free_q <= pwdata;
         end else if (addOkEvt != removeOkEvt) begin
            free_q <= addOkEvt ? free_q - 32'h1 : free_q + 32'h1;
         end
         if (queryEnd) begin
            len_q[7:0] <= cmdDoneLen;
         end else if (wrLen) begin
            len_q <= pwdata;
         end
      end
   end

   // ****************************************************************
   // Statistics: usage and failure writable, match and miss clear on read.
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ustat_q <= 32'h0000_0000;
         fstat_q <= 32'h0000_0000;
      end else begin
         ustat_q <= (wrUstat ? pwdata : ustat_q) +
            {15'h0000, removeOkEvt, 15'h0000, addOkEvt};
         fstat_q <= (wrFstat ? pwdata : fstat_q) +
            {15'h0000, removeFailEvt, 15'h0000, addFailEvt};
      end
   end

   // An event in the reading cycle survives the clear.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         match_q <= 32'h0000_0000;
         miss_q <= 32'h0000_0000;
      end else begin
         match_q <= (rdMatch ? 32'h0 : match_q) + {31'h0, matchEvt};
         miss_q <= (rdMiss ? 32'h0 : miss_q) + {31'h0, missEvt};
      end
   end

   // ****************************************************************
   // Read data, captured in the setup cycle.
   // ****************************************************************
   logic [31:0] rdMux;
   always_comb begin
      unique case (paddr)
         OFS_CTRL: rdMux = ctrl_q;
         OFS_FREE: rdMux = free_q;
         OFS_HASH: rdMux = hash_q;
         OFS_CMD: rdMux = cmd_q;
         OFS_USTAT: rdMux = ustat_q;
         OFS_FSTAT: rdMux = fstat_q;
         OFS_MATCH: rdMux = match_q;
         OFS_MISS: rdMux = miss_q;
         OFS_LEN: rdMux = len_q;
         OFS_HKEY: rdMux = hkey_q;
         OFS_SKEY: rdMux = skey_q;
         OFS_RESULT: rdMux = {signatureHash, 1'b0, bucketHash};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         rdata_q <= rdMux;
      end
   end

   // ****************************************************************
   // Tuple assembly and the two keyed hashes.
   // ****************************************************************
   wire [127:0] srcIp = pktTunnel ? pktInnerSrcIp : pktOuterSrcIp;
   wire [127:0] dstIp = pktTunnel ? pktInnerDstIp : pktOuterDstIp;
   wire [335:0] tupleRaw = {pktVlan, srcIp, dstIp, pktSrcPort, pktDstPort, pktFlex};
   wire [335:0] tupleMasked = tupleRaw & tupleMask;
   wire [15:0] bucketFull;

   // Bucket and signature hashes share structure, differ in key.
   fftc_hash u_bucket (
      .clk(clk),
      .rstn(rstn),
      .load(pktValid),
      .key(hkey_q),
      .tuple(tupleMasked),
      .hash(bucketFull)
   );
   fftc_hash u_signature (
      .clk(clk),
      .rstn(rstn),
      .load(pktValid),
      .key(skey_q),
      .tuple(tupleMasked),
      .hash(signatureHash)
   );

   assign bucketHash = bucketFull[14:0];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         hashValid_q <= 1'b0;
      end else begin
         hashValid_q <= pktValid;
      end
   end

   assign hashValid = hashValid_q;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   localparam int CMD_BOUND = 4;

   a_apb_ready_now: assert property (@(posedge clk) disable iff (!rstn)
      psel && penable |-> pready)
      else $error("Access phase without ready.");
   a_cmd_bounded_time: assert property (@(posedge clk) disable iff (!rstn)
      $rose(cmdPending) |-> ##[1:CMD_BOUND] !cmdPending)
      else $error("Pending command did not clear in time.");
   a_cmd_done_clear: assert property (@(posedge clk) disable iff (!rstn)
      cmdPending && cmdDone |=> cmdCode == FFTC_CMD_IDLE)
      else $error("Command code not cleared on completion.");
   a_cmd_start_pulse: assert property (@(posedge clk) disable iff (!rstn)
      cmdGo |=> cmdStart && cmdCode == $past(codeWr))
      else $error("Command write did not start programming.");
   a_query_pool_zero: assert property (@(posedge clk) disable iff (!rstn)
      queryEnd && sigMode |=> cmd_q[CMD_POOL_LSB +: 6] == 6'h00)
      else $error("Pool returned in signature mode.");
   a_init_on_alloc: assert property (@(posedge clk) disable iff (!rstn)
      wrCtrl && allocWr != 3'h0 |=> initBusy && !ctrl_q[CTRL_INIT_DONE])
      else $error("Nonzero allocation did not start initialisation.");
   a_init_done_flag: assert property (@(posedge clk) disable iff (!rstn)
      $fell(initBusy) && !$past(wrCtrl) |-> ctrl_q[CTRL_INIT_DONE])
      else $error("Init flag not set after initialisation.");
   a_match_read_clear: assert property (@(posedge clk) disable iff (!rstn)
      rdMatch |=> match_q == {31'h0, $past(matchEvt)})
      else $error("Match counter not cleared by read.");
   a_bucket_lsb_map: assert property (@(posedge clk) disable iff (!rstn)
      bucketHash == bucketFull[14:0] && hashValid == $past(pktValid))
      else $error("Bucket hash not taken from low bits.");

   c_query_done: cover property (@(posedge clk) disable iff (!rstn) queryEnd);
   c_init_finish: cover property (@(posedge clk) disable iff (!rstn) initLast);
   c_read_evt_race: cover property (@(posedge clk) disable iff (!rstn)
      rdMatch && matchEvt);
   c_cmd_timeout: cover property (@(posedge clk) disable iff (!rstn) cmdTimeout);
endmodule

// ==== fftc_pkg.sv ====
package fftc_pkg;
   // ****************************************************************
   // Register offsets (byte addresses on the APB bus).
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FREE = 8'h04;
   localparam logic [7:0] OFS_HASH = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h0c;
   localparam logic [7:0] OFS_USTAT = 8'h10;
   localparam logic [7:0] OFS_FSTAT = 8'h14;
   localparam logic [7:0] OFS_MATCH = 8'h18;
   localparam logic [7:0] OFS_MISS = 8'h1c;
   localparam logic [7:0] OFS_LEN = 8'h20;
   localparam logic [7:0] OFS_HKEY = 8'h24;
   localparam logic [7:0] OFS_SKEY = 8'h28;
   localparam logic [7:0] OFS_RESULT = 8'h2c;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int CTRL_ALLOC_LSB = 0;
   localparam int CTRL_INIT_DONE = 3;
   localparam int CTRL_SIG_MODE = 4;
   localparam int CTRL_SPEED_LSB = 5;
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_CLEAR_HT = 3;
   localparam int CMD_UPDATE = 4;
   localparam int CMD_ACTION_LSB = 8;
   localparam int CMD_POOL_LSB = 16;

   // ****************************************************************
   // Reset values.
   // ****************************************************************
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] KEY_RESET = 32'h0000_0000;

   // ****************************************************************
   // Timing: initialisation times and the command completion limit.
   // ****************************************************************
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned INIT_10G_NS = 55000;
   localparam int unsigned INIT_1G_NS = 550000;
   localparam int unsigned INIT_100M_NS = 5500000;
   localparam int unsigned INIT_CYC_10G = INIT_10G_NS * CLK_MHZ / 1000;
   localparam int unsigned INIT_CYC_1G = INIT_1G_NS * CLK_MHZ / 1000;
   localparam int unsigned INIT_CYC_100M = INIT_100M_NS * CLK_MHZ / 1000;
   localparam logic [2:0] CMD_MAX_CYC = 3'h3;

   // Table command codes and link speed codes.
   typedef enum logic [1:0] {
      FFTC_CMD_IDLE = 2'b00,
      FFTC_CMD_ADD = 2'b01,
      FFTC_CMD_REMOVE = 2'b10,
      FFTC_CMD_QUERY = 2'b11
   } fftc_cmd_t;
   typedef enum logic [1:0] {
      FFTC_SPD_10G = 2'b00,
      FFTC_SPD_1G = 2'b01,
      FFTC_SPD_100M = 2'b10,
      FFTC_SPD_RSVD = 2'b11
   } fftc_speed_t;
endpackage

// ==== fftc_hash.sv ====
`timescale 1ns/1ns
module fftc_hash (
   input wire logic clk,
   input wire logic rstn,
   input wire logic load,
   input wire logic [31:0] key,
   input wire logic [335:0] tuple,
   output logic [15:0] hash
);
   import fftc_pkg::*;

   // ****************************************************************
   // Keyed hash over the masked tuple string.
   // ****************************************************************
   logic [365:0] extInput;
   logic [351:0] tmpKey;
   logic [350:0] extKey;
   logic [15:0] hash_d;
   logic [15:0] hash_q;

   // Extended input wraps the string at both ends; extended key drops bit 0.
   assign extInput = {tuple[14:0], tuple, tuple[335:321]};
   assign tmpKey = {11{key}};
   assign extKey = tmpKey[351:1];

   // Accumulate one 16-bit window for every key bit that is set.
   always_comb begin
      hash_d = 16'h0000;
      for (int i = 0; i < 351; i++) begin
         if (extKey[i]) begin
            hash_d = hash_d ^ extInput[i +: 16];
         end
      end
   end

   // The result is held until the next tuple is loaded.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hash_q <= 16'h0000;
      end else if (load) begin
         hash_q <= hash_d;
      end
   end

   assign hash = hash_q;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   a_hash_zero_key: assert property (@(posedge clk) disable iff (!rstn)
      load && key == 32'h0000_0000 |=> hash == 16'h0000)
      else $error("Hash with an all-zero key is not zero.");
endmodule

// ==== fftc_table_ctrl_tb_top.sv ====
`timescale 1ns/1ns
module fftc_table_ctrl_tb_top;
   import fftc_pkg::*;
   // ****************************************************************
   // Stimulus and observed signals.
   // ****************************************************************
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, ex;
   logic pready, pslverr, cmdStart, cmdUpdate, tableClear, tableEnable, initBusy, sigMode;
   logic hashValid, err;
   logic [1:0] cmdCode;
   logic [2:0] bufferAllocation;
   logic [31:0] cmdHashSig;
   logic cmdDone = 0, matchEvt = 0, missEvt = 0, addOkEvt = 0, removeOkEvt = 0;
   logic addFailEvt = 0, removeFailEvt = 0, pktValid = 0, pktTunnel = 0;
   logic [31:0] cmdDoneHash = 0, pktFlex = 32'h0bad_f00d;
   logic [7:0] cmdDoneAction = 0, cmdDoneLen = 0;
   logic [5:0] cmdDonePool = 0;
   logic [15:0] pktVlan = 16'ha5c3, pktSrcPort = 16'h1f90, pktDstPort = 16'h0050, hs;
   logic [127:0] pktOuterSrcIp = {4{32'h0a01_0203}}, pktOuterDstIp = {4{32'hc0a8_0001}};
   logic [127:0] pktInnerSrcIp = {4{32'h1357_9bdf}}, pktInnerDstIp = {4{32'h2468_ace0}};
   logic [335:0] tupleMask = {{320{1'b1}}, 16'h0f0f}, tup;
   logic [14:0] bucketHash, hb;
   logic [15:0] signatureHash;
   int bad_count = 0;
   int comparisons = 0;
   int n;

   // The design under test, with short initialisation counts.
   fftc_table_ctrl #(.INIT_CYC_10G(20), .INIT_CYC_1G(30), .INIT_CYC_100M(40)) i_fftc_table_ctrl (
      .clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .cmdStart, .cmdCode, .cmdUpdate, .cmdHashSig, .cmdDone, .cmdDoneHash, .cmdDoneAction,
      .cmdDonePool, .cmdDoneLen, .tableClear, .tableEnable, .initBusy, .sigMode,
      .bufferAllocation, .matchEvt, .missEvt, .addOkEvt, .removeOkEvt, .addFailEvt,
      .removeFailEvt, .pktValid, .pktTunnel, .pktVlan, .pktOuterSrcIp, .pktOuterDstIp,
      .pktInnerSrcIp, .pktInnerDstIp, .pktSrcPort, .pktDstPort, .pktFlex, .tupleMask,
      .bucketHash, .signatureHash, .hashValid);

   // ****************************************************************
   // Bus tasks, comparison and reference hash.
   // ****************************************************************
   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, msg);
   endtask
   // XOR of 16-bit windows of the wrapped input where the extended key bit is set.
   function automatic logic [15:0] refHash(input logic [31:0] k, input logic [335:0] s);
      logic [365:0] es;
      logic [351:0] tk;
      logic [15:0] h;
      es = {s[14:0], s, s[335:321]};
      tk = {11{k}};
      h = 16'h0000;
      for (int i = 0; i <= 350; i++) if (tk[i+1]) h ^= es[i+15 -: 16];
      return h;
   endfunction
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Clock and watchdog.
   initial forever #5 clk = ~clk;
   initial begin
      #100000;
      bad_count++;
      $display("FAIL %0t watchdog expired", $time);
      close_out;
   end

   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rdc(OFS_CTRL, CTRL_RESET, "ctrl after reset");
      rdc(OFS_CMD, 32'h0, "cmd after reset");
      $display("test reset done");
      // Each speed: flag drops on the write, sets after the speed's count.
      for (int s = 2; s >= 0; s--) begin
         ex = (32'(s) << 5) | 32'h1;
         wr(OFS_CTRL, ex | 32'h8);
         rdc(OFS_CTRL, ex, "init flag not cleared");
         n = 3;
         while (initBusy === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         ex = ex | 32'h8;
         chk(32'(n >= (s == 0 ? 18 : s == 1 ? 28 : 38)), 1, "init too short");
         chk(32'(n <= (s == 0 ? 22 : s == 1 ? 32 : 42)), 1, "init too long");
         rdc(OFS_CTRL, ex, "init flag not set");
         chk({29'h0, bufferAllocation}, 32'h1, "allocation");
         chk({31'h0, tableEnable}, 32'h1, "table enable");
      end
      $display("test init done");
      wr(OFS_CMD, 32'(FFTC_CMD_ADD));
      #1 chk({31'h0, cmdStart}, 1, "no start pulse");
      apb(1'b0, OFS_CMD, 32'h0);
      rdc(OFS_CMD, 32'h0, "code not cleared by second read");
      $display("test pending done");
      for (int sm = 0; sm < 2; sm++) begin
         wr(OFS_CTRL, 32'h1 | (32'(sm) << 4));
         wr(OFS_HASH, 32'h1234_5678);
         #1 chk(cmdHashSig, 32'h1234_5678, "hash to engine");
         chk({31'h0, sigMode}, 32'(sm), "signature mode");
         wr(OFS_CMD, 32'(FFTC_CMD_QUERY));
         cmdDone <= 1'b1;
         cmdDoneHash <= 32'hcafe_0000 | 32'(sm);
         cmdDoneAction <= 8'h5a;
         cmdDonePool <= 6'h2b;
         cmdDoneLen <= 8'h07;
         #1 chk({30'h0, cmdCode}, 32'h3, "query not pending");
         @(posedge clk) cmdDone <= 1'b0;
         rdc(OFS_HASH, 32'hcafe_0000 | 32'(sm), "query hash");
         ex = {10'h0, (sm == 1) ? 6'h00 : 6'h2b, 8'h5a, 8'h00};
         rdc(OFS_CMD, ex, "query action");
         rdc(OFS_LEN, 32'h7, "query length");
      end
      $display("test query done");
      wr(OFS_FREE, 32'h0);
      wr(OFS_CMD, 32'h18);
      #1 chk({31'h0, tableClear}, 1, "clear not applied");
      chk({31'h0, cmdUpdate}, 1, "update bit");
      wr(OFS_CMD, 32'h0);
      #1 chk({31'h0, tableClear}, 0, "clear not released");
      wr(OFS_HASH, 32'h0);
      rdc(OFS_HASH, 32'h0, "hash not zeroed");
      $display("test clear done");
      wr(OFS_FREE, 32'h5);
      @(posedge clk);
      matchEvt <= 1'b1;
      addOkEvt <= 1'b1;
      missEvt <= 1'b1;
      removeFailEvt <= 1'b1;
      repeat (2) @(posedge clk);
      matchEvt <= 1'b0;
      addOkEvt <= 1'b0;
      missEvt <= 1'b0;
      removeFailEvt <= 1'b0;
      rdc(OFS_MATCH, 32'h2, "match count");
      rdc(OFS_MISS, 32'h2, "miss count");
      rdc(OFS_FSTAT, 32'h0002_0000, "failure count");
      rdc(OFS_MATCH, 32'h0, "match not cleared on read");
      rdc(OFS_USTAT, 32'h2, "usage count");
      rdc(OFS_FREE, 32'h3, "free count");
      wr(OFS_USTAT, 32'h0);
      rdc(OFS_USTAT, 32'h0, "usage not writable");
      apb(1'b0, 8'h30, 32'h0);
      chk({31'h0, err}, 1, "unmapped not refused");
      $display("test stats done");
      wr(OFS_HKEY, 32'h8d3c_51a7);
      wr(OFS_SKEY, 32'h29e4_b60f);
      for (int t = 0; t < 2; t++) begin
         tup = {pktVlan, t ? pktInnerSrcIp : pktOuterSrcIp, t ? pktInnerDstIp : pktOuterDstIp,
                pktSrcPort, pktDstPort, pktFlex} & tupleMask;
         hs = refHash(32'h8d3c_51a7, tup);
         hb = hs[14:0];
         hs = refHash(32'h29e4_b60f, tup);
         @(posedge clk);
         pktTunnel <= t[0];
         pktValid <= 1'b1;
         @(posedge clk);
         pktValid <= 1'b0;
         #1 chk({31'h0, hashValid}, 1, "hash valid");
         chk({17'h0, bucketHash}, {17'h0, hb}, "bucket hash");
         chk({16'h0, signatureHash}, {16'h0, hs}, "signature hash");
         rdc(OFS_RESULT, {hs, 1'b0, hb}, "hash result register");
      end
      $display("test hash done");
      close_out;
   end
endmodule
